/* File: common/eepc_pkg.sv */
`default_nettype none

package eepc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IDX_W    = 10;
  localparam int unsigned IDX_LSB  = 2;

  // ----------------------------------------------------------------
  // Register and array map, as word indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] CTRL_IDX     = 10'h007;
  localparam logic [IDX_W-1:0] ARRAY_FIRST  = 10'h100;
  localparam logic [IDX_W-1:0] ARRAY_LAST   = 10'h1FF;
  localparam int unsigned      ARRAY_DEPTH  = 256;
  localparam logic [7:0]       OPTION_LOC   = 8'h00;

  // ----------------------------------------------------------------
  // Control register fields and reset value
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W          = 4;
  localparam int unsigned BIT_PGM         = 0;
  localparam int unsigned BIT_LAT         = 1;
  localparam int unsigned BIT_ERA         = 2;
  localparam int unsigned BIT_AUX         = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 4'h0;

  // ----------------------------------------------------------------
  // Array contents and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Address and data captured for one program or erase operation.
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } eepc_cap_s;

endpackage

`default_nettype wire

/* File: verilog/eepc_top.sv */
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Array is 256 bytes, indices 0x100 to 0x1FF.
// - 255 general bytes, one holds option byte.
// - Only single bytes erase; no bulk erase.
// - Control register at index 7, upper bits zero.
// - With latch and voltage set, erase_select picks operation.
// - erase_select frozen once target address captured.
// - Erased byte reads back 0xFF.
module eepc_top (
  input  wire logic                          CORE_CLK_I,
  input  wire logic                          RSTN_I,
  input  wire logic                          CE_I,
  input  wire logic [eepc_pkg::ADDR_W-1:0]   AWADDR_I,
  input  wire logic                          AWVALID_I,
  output var  logic                          AWREADY_O,
  input  wire logic [eepc_pkg::DATA_W-1:0]   WDATA_I,
  input  wire logic [3:0]                    WSTRB_I,
  input  wire logic                          WVALID_I,
  output var  logic                          WREADY_O,
  output var  logic [1:0]                    BRESP_O,
  output var  logic                          BVALID_O,
  input  wire logic                          BREADY_I,
  input  wire logic [eepc_pkg::ADDR_W-1:0]   ARADDR_I,
  input  wire logic                          ARVALID_I,
  output var  logic                          ARREADY_O,
  output var  logic [eepc_pkg::DATA_W-1:0]   RDATA_O,
  output var  logic [1:0]                    RRESP_O,
  output var  logic                          RVALID_O,
  input  wire logic                          RREADY_I,
  output var  logic                          PUMP_ON_O,
  output var  logic                          AUX_CLOCK_SELECT_O,
  output var  logic [7:0]                    OPTION_BYTE_O
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Word index of a byte address.
  function automatic logic [eepc_pkg::IDX_W-1:0] word_idx(input logic [eepc_pkg::ADDR_W-1:0] a);
    return a[eepc_pkg::ADDR_W-1:eepc_pkg::IDX_LSB];
  endfunction

  // True when the index falls inside the nonvolatile array.
  function automatic logic in_array(input logic [eepc_pkg::IDX_W-1:0] i);
    return (i >= eepc_pkg::ARRAY_FIRST) && (i <= eepc_pkg::ARRAY_LAST);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [eepc_pkg::ADDR_W-1:0]    aw_addr_r;
  logic                           aw_held_r;
  logic [7:0]                     w_byte_r;
  logic                           w_lane0_r;
  logic                           w_held_r;
  logic                           bvalid_r;
  logic [1:0]                     bresp_r;
  logic                           rvalid_r;
  logic [1:0]                     rresp_r;
  logic [eepc_pkg::DATA_W-1:0]    rdata_r;
  logic [eepc_pkg::CTRL_W-1:0]    ctrl_r;
  logic [eepc_pkg::CTRL_W-1:0]    ctrl_nxt;
  eepc_pkg::eepc_cap_s            cap_r;
  eepc_pkg::eepc_cap_s            cap_nxt;
  logic [7:0]                     mem_r [eepc_pkg::ARRAY_DEPTH];

  // ----------------------------------------------------------------
  // Write path decode
  // ----------------------------------------------------------------

  // A write is carried out once address and data are both held and no
  // response is still waiting, so one write is under way at a time.
  wire                          aw_take   = AWVALID_I && AWREADY_O;
  wire                          w_take    = WVALID_I && WREADY_O;
  wire                          wr_go     = aw_held_r && w_held_r && !bvalid_r;
  wire [eepc_pkg::IDX_W-1:0]    wr_idx    = word_idx(aw_addr_r);
  wire                          wr_ctrl   = wr_go && (wr_idx == eepc_pkg::CTRL_IDX);
  wire                          wr_arr    = wr_go && in_array(wr_idx);
  wire                          wr_ok     = (wr_idx == eepc_pkg::CTRL_IDX) || in_array(wr_idx);
  wire [7:0]                    wr_loc    = wr_idx[7:0];
  wire                          lat_on    = ctrl_r[eepc_pkg::BIT_LAT];
  wire                          pgm_on    = ctrl_r[eepc_pkg::BIT_PGM];

  // Byte writes into the array only capture while the latch is on and the
  // pump is still off; otherwise the array behaves as read-only storage.
  wire                          cap_load  = wr_arr && w_lane0_r && lat_on && !pgm_on && !cap_r.valid;

  // Control update: upper nibble is never stored, erase_select is frozen
  // while a target is captured.
  wire                          ctl_wr    = wr_ctrl && w_lane0_r;
  wire                          era_new   = cap_r.valid ? ctrl_r[eepc_pkg::BIT_ERA]
                                                          : w_byte_r[eepc_pkg::BIT_ERA];
  wire [eepc_pkg::CTRL_W-1:0]   ctl_wval  = {w_byte_r[eepc_pkg::BIT_AUX], era_new,
                                             w_byte_r[eepc_pkg::BIT_LAT], w_byte_r[eepc_pkg::BIT_PGM]};

  // The high-voltage phase ends when software drops the voltage bit with
  // the latch still set; the operation then lands on the captured byte.
  wire                          pgm_fall  = ctl_wr && pgm_on && lat_on && !w_byte_r[eepc_pkg::BIT_PGM];
  wire                          commit    = pgm_fall && cap_r.valid;
  wire                          do_erase  = commit && ctrl_r[eepc_pkg::BIT_ERA];
  wire                          do_prog   = commit && !ctrl_r[eepc_pkg::BIT_ERA];

  assign ctrl_nxt = ctl_wr ? ctl_wval : ctrl_r;

  // Capture is dropped when the latch goes off or the operation completes.
  always_comb begin
    cap_nxt = cap_r;
    if (cap_load) begin
      cap_nxt.valid = 1'b1;
      cap_nxt.addr  = wr_loc;
      cap_nxt.data  = w_byte_r;
    end
    if (commit || (ctl_wr && !w_byte_r[eepc_pkg::BIT_LAT])) begin
      cap_nxt.valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read path decode
  // ----------------------------------------------------------------

  // The bus reads one address byte at a time; OPTION_BYTE_O reads location 0 in parallel as a
  // second read port, and the core reads the array as ordinary memory.
  wire                          ar_take   = ARVALID_I && ARREADY_O;
  wire [eepc_pkg::IDX_W-1:0]    rd_idx    = word_idx(ARADDR_I);
  wire                          rd_ctrl   = rd_idx == eepc_pkg::CTRL_IDX;
  wire                          rd_arr    = in_array(rd_idx);
  wire [7:0]                    rd_byte   = rd_ctrl ? {4'h0, ctrl_r}
                                          : rd_arr  ? mem_r[rd_idx[7:0]] : 8'h00;

  // ----------------------------------------------------------------
  // Bus handshake registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r  <= 1'b0;
      w_byte_r  <= 8'h00;
      w_lane0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= eepc_pkg::RESP_OKAY;
      AWREADY_O <= 1'b0;
      WREADY_O  <= 1'b0;
    end else if (CE_I) begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= AWADDR_I;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r  <= 1'b1;
        w_byte_r  <= WDATA_I[7:0];
        w_lane0_r <= WSTRB_I[0];
      end else if (wr_go) begin
        w_held_r  <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok ? eepc_pkg::RESP_OKAY : eepc_pkg::RESP_SLVERR;
      end else if (BREADY_I) begin
        bvalid_r <= 1'b0;
      end
      AWREADY_O <= !aw_held_r && !aw_take && !wr_go && !bvalid_r;
      WREADY_O  <= !w_held_r && !w_take && !wr_go && !bvalid_r;
    end
  end

  // Read answers one cycle after the address is taken.
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= eepc_pkg::RESP_OKAY;
      ARREADY_O <= 1'b0;
    end else if (CE_I) begin
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h00_0000, rd_byte};
        rresp_r  <= (rd_ctrl || rd_arr) ? eepc_pkg::RESP_OKAY : eepc_pkg::RESP_SLVERR;
      end else if (RREADY_I) begin
        rvalid_r <= 1'b0;
      end
      ARREADY_O <= !rvalid_r && !ar_take;
    end
  end

  // ----------------------------------------------------------------
  // Control, capture and array
  // ----------------------------------------------------------------

  // Control and capture state.
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl_r <= eepc_pkg::CTRL_RST;
      cap_r  <= '0;
    end else if (CE_I) begin
      ctrl_r <= ctrl_nxt;
      cap_r  <= cap_nxt;
    end
  end

  // Only the one captured byte is ever touched, so no bulk path exists.
  // Programming can only clear bits, as a real cell does.
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int i = 0; i < eepc_pkg::ARRAY_DEPTH; i++) begin
        mem_r[i] <= eepc_pkg::ERASED_BYTE;
      end
    end else if (CE_I) begin
      if (do_erase) begin
        mem_r[cap_r.addr] <= eepc_pkg::ERASED_BYTE;
      end else if (do_prog) begin
        mem_r[cap_r.addr] <= mem_r[cap_r.addr] & cap_r.data;
      end
    end
  end

  // Side outputs, each taken from its own flop.
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PUMP_ON_O          <= 1'b0;
      AUX_CLOCK_SELECT_O <= 1'b0;
      OPTION_BYTE_O      <= eepc_pkg::ERASED_BYTE;
    end else if (CE_I) begin
      PUMP_ON_O          <= ctrl_nxt[eepc_pkg::BIT_LAT] && ctrl_nxt[eepc_pkg::BIT_PGM];
      AUX_CLOCK_SELECT_O <= ctrl_nxt[eepc_pkg::BIT_AUX];
      OPTION_BYTE_O      <= mem_r[eepc_pkg::OPTION_LOC];
    end
  end

  assign BVALID_O = bvalid_r;
  assign BRESP_O  = bresp_r;
  assign RVALID_O = rvalid_r;
  assign RDATA_O  = rdata_r;
  assign RRESP_O  = rresp_r;

endmodule // eepc_top

`default_nettype wire

/* File: verification/eepc_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Bus timing and control register checks at the top ports
// ------------------------------------------------------------
module eepc_top_assertions (
  input wire logic                        CORE_CLK_I,
  input wire logic                        RSTN_I,
  input wire logic [eepc_pkg::ADDR_W-1:0] AWADDR_I,
  input wire logic                        AWVALID_I,
  input wire logic                        AWREADY_O,
  input wire logic [eepc_pkg::DATA_W-1:0] WDATA_I,
  input wire logic                        WVALID_I,
  input wire logic                        WREADY_O,
  input wire logic                        BVALID_O,
  input wire logic                        BREADY_I,
  input wire logic [eepc_pkg::ADDR_W-1:0] ARADDR_I,
  input wire logic                        ARVALID_I,
  input wire logic                        ARREADY_O,
  input wire logic [eepc_pkg::DATA_W-1:0] RDATA_O,
  input wire logic [1:0]                  RRESP_O,
  input wire logic                        RVALID_O,
  input wire logic                        RREADY_I,
  input wire logic                        PUMP_ON_O,
  input wire logic                        AUX_CLOCK_SELECT_O
);
  logic [11:0] wa_r;
  logic [7:0]  wd_r;
  // Clock enable is held high by the bench, so takes are judged on valid and ready alone.
  // Any byte of the control word decodes to the control register, as in the design's word index.
  wire  logic  ar_ok = (ARADDR_I[11:2] == 10'h007) || (ARADDR_I >= 12'h400 && ARADDR_I <= 12'h7FF);

  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // Keep the last accepted write so its answer can be judged when the response appears.
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wa_r <= 12'h000;
      wd_r <= 8'h00;
    end else begin
      if (AWVALID_I && AWREADY_O) wa_r <= AWADDR_I;
      if (WVALID_I && WREADY_O) wd_r <= WDATA_I[7:0];
    end
  end

  // Steps of a transfer.
  sequence s_wr_take;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  sequence s_rd_take;
    ARVALID_I && ARREADY_O;
  endsequence
  sequence s_ctrl_done;
    $rose(BVALID_O) && wa_r[11:2] == 10'h007;
  endsequence

  // Response timing, register map and control outputs.
  a_write_answer_time: assert property (s_wr_take |=> !BVALID_O ##1 BVALID_O)
    else $error("write response not two cycles after take");
  a_write_done_ready: assert property (BVALID_O && BREADY_I |=> !BVALID_O ##1 AWREADY_O)
    else $error("write response did not retire in time");
  a_read_answer_time: assert property (s_rd_take |=> RVALID_O)
    else $error("read data not one cycle after take");
  a_read_done_ready: assert property (RVALID_O && RREADY_I |=> !RVALID_O ##1 ARREADY_O)
    else $error("read response did not retire in time");
  a_unmapped_read_err: assert property ((s_rd_take and (!ar_ok)) |=>
      RRESP_O == 2'h2 && RDATA_O == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_ctrl_upper_zero: assert property ((s_rd_take and (ARADDR_I[11:2] == 10'h007)) |=>
      RDATA_O[31:4] == 28'h000_0000)
    else $error("control read upper bits not zero");
  a_pump_from_ctrl: assert property (s_ctrl_done |-> PUMP_ON_O == (wd_r[1] & wd_r[0]))
    else $error("pump output does not follow latch and voltage bits");
  a_aux_from_ctrl: assert property (s_ctrl_done |-> AUX_CLOCK_SELECT_O == wd_r[3])
    else $error("aux select output does not follow control bit");
endmodule // eepc_top_assertions

bind eepc_top eepc_top_assertions chk_u (.*);

`default_nettype wire

/* File: verification/eepc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// CPU side bus master reaching the array space
// ------------------------------------------------------------
module eepc_cpu_model (
  input  wire logic        clk_i,
  output var  logic [11:0] aw_addr_o,
  output var  logic        aw_valid_o,
  input  wire logic        aw_ready_i,
  output var  logic [31:0] w_data_o,
  output var  logic [3:0]  w_strb_o,
  output var  logic        w_valid_o,
  input  wire logic        w_ready_i,
  input  wire logic [1:0]  b_resp_i,
  input  wire logic        b_valid_i,
  output var  logic        b_ready_o,
  output var  logic [11:0] ar_addr_o,
  output var  logic        ar_valid_o,
  input  wire logic        ar_ready_i,
  input  wire logic [31:0] r_data_i,
  input  wire logic [1:0]  r_resp_i,
  input  wire logic        r_valid_i,
  output var  logic        r_ready_o
);
  // Idle bus; all valid, ready, address, data and strobe outputs start at zero.
  initial begin
    {aw_addr_o, aw_valid_o, w_data_o, w_strb_o, w_valid_o, b_ready_o} = '0;
    {ar_addr_o, ar_valid_o, r_ready_o} = '0;
  end

  // One write: both channels offered together, each dropped and scrambled once taken.
  // The master waits for as long as the answer takes; only the bench's watchdog ends a hang.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    r = 2'h3;
    @(posedge clk_i);
    aw_addr_o <= a;
    w_data_o <= {24'h00_0000, d};
    w_strb_o <= 4'h1;
    aw_valid_o <= 1'b1;
    w_valid_o <= 1'b1;
    b_ready_o <= 1'b1;
    while (r === 2'h3) begin
      @(posedge clk_i);
      if (aw_valid_o && aw_ready_i) aw_valid_o <= 1'b0;
      if (aw_valid_o && aw_ready_i) aw_addr_o <= ~a;
      if (w_valid_o && w_ready_i) w_valid_o <= 1'b0;
      if (w_valid_o && w_ready_i) w_data_o <= ~w_data_o;
      if (b_valid_i) r = b_resp_i;
    end
    b_ready_o <= 1'b0;
  endtask

  // One read; the answer is taken at the edge where valid is seen.
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    @(posedge clk_i);
    ar_addr_o <= a;
    ar_valid_o <= 1'b1;
    r_ready_o <= 1'b1;
    while (r === 2'h3) begin
      @(posedge clk_i);
      if (ar_valid_o && ar_ready_i) ar_valid_o <= 1'b0;
      if (ar_valid_o && ar_ready_i) ar_addr_o <= ~a;
      if (r_valid_i) d = r_data_i;
      if (r_valid_i) r = r_resp_i;
    end
    r_ready_o <= 1'b0;
  endtask
endmodule // eepc_cpu_model

`default_nettype wire

/* File: verification/eepc_byte_program_erase_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Self-checking bench for the array control block
// ------------------------------------------------------------
module eepc_byte_program_erase_ctrl_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, rdv;
  logic [3:0]  w_s;
  logic [1:0]  b_r, r_r, rsp;
  logic        aw_v, aw_rdy, w_v, w_rdy, b_v, b_rdy, ar_v, ar_rdy, r_v, r_rdy, pump, aux;
  logic [7:0]  opt;
  int          miscompares = 0;
  int          checks = 0;

  // 20 MHz core clock.
  always #25 clk = ~clk;

  // Clock enable stays high: a frozen bus would only stretch every wait.
  eepc_top dut_u (
    .CORE_CLK_I(clk), .RSTN_I(rst_n), .CE_I(1'b1), .AWADDR_I(aw_a), .AWVALID_I(aw_v), .AWREADY_O(aw_rdy),
    .WDATA_I(w_d), .WSTRB_I(w_s), .WVALID_I(w_v), .WREADY_O(w_rdy), .BRESP_O(b_r), .BVALID_O(b_v),
    .BREADY_I(b_rdy), .ARADDR_I(ar_a), .ARVALID_I(ar_v), .ARREADY_O(ar_rdy), .RDATA_O(r_d), .RRESP_O(r_r),
    .RVALID_O(r_v), .RREADY_I(r_rdy), .PUMP_ON_O(pump), .AUX_CLOCK_SELECT_O(aux), .OPTION_BYTE_O(opt));
  eepc_cpu_model cpu_u (
    .clk_i(clk), .aw_addr_o(aw_a), .aw_valid_o(aw_v), .aw_ready_i(aw_rdy), .w_data_o(w_d), .w_strb_o(w_s),
    .w_valid_o(w_v), .w_ready_i(w_rdy), .b_resp_i(b_r), .b_valid_i(b_v), .b_ready_o(b_rdy), .ar_addr_o(ar_a),
    .ar_valid_o(ar_v), .ar_ready_i(ar_rdy), .r_data_i(r_d), .r_resp_i(r_r), .r_valid_i(r_v), .r_ready_o(r_rdy));

  // Comparison and bus helpers.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic w(input logic [11:0] a, input logic [7:0] d);
    cpu_u.wr(a, d, rsp);
    chk("bresp", 32'(rsp), 32'(eepc_pkg::RESP_OKAY));
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
    cpu_u.rd(a, rdv, rsp);
    chk(nm, rdv, e);
    chk("rresp", 32'(rsp), 32'(er));
  endtask
  // Latch a byte, raise the voltage bit, then clear it to commit.
  task automatic op(input logic [11:0] a, input logic [7:0] d, input logic e);
    w(12'h01C, {5'h00, e, 2'h2});
    w(a, d);
    w(12'h01C, {5'h00, e, 2'h3});
    chk("pump", 32'(pump), 32'h0000_0001);
    w(12'h01C, {5'h00, e, 2'h2});
    chk("pump_off", 32'(pump), 32'h0000_0000);
    w(12'h01C, 8'h00);
  endtask

  // Scenarios.
  task automatic t_reset;
    rc(12'h01C, 32'h0000_0000, 2'h0, "ctrl");
    rc(12'h7FC, 32'h0000_00FF, 2'h0, "last");
    chk("option", 32'(opt), 32'h0000_00FF);
  endtask
  task automatic t_program;
    op(12'h400, 8'h3C, 1'b0);
    op(12'h404, 8'hA5, 1'b0);
    op(12'h404, 8'h0F, 1'b0);
    rc(12'h404, 32'h0000_0005, 2'h0, "prog");
    chk("option", 32'(opt), 32'h0000_003C);
  endtask
  task automatic t_erase;
    w(12'h01C, 8'h06);
    w(12'h404, 8'h00);
    w(12'h01C, 8'h02);
    rc(12'h01C, 32'h0000_0006, 2'h0, "frozen");
    w(12'h01C, 8'h07);
    w(12'h01C, 8'h06);
    w(12'h01C, 8'h00);
    rc(12'h404, 32'h0000_00FF, 2'h0, "erased");
    rc(12'h400, 32'h0000_003C, 2'h0, "neighbour");
  endtask
  task automatic t_map;
    rc(12'h3FC, 32'h0000_0000, eepc_pkg::RESP_SLVERR, "below");
    rc(12'h800, 32'h0000_0000, eepc_pkg::RESP_SLVERR, "above");
    cpu_u.wr(12'h800, 8'h00, rsp);
    chk("wresp", 32'(rsp), 32'(eepc_pkg::RESP_SLVERR));
    // An array write with the latch off must leave the byte erased.
    w(12'h408, 8'h00);
    rc(12'h408, 32'h0000_00FF, 2'h0, "unlatched");
    // Dropping the latch discards the capture, so a later voltage pulse lands nowhere.
    w(12'h01C, 8'h02);
    w(12'h408, 8'h00);
    w(12'h01C, 8'h00);
    w(12'h01C, 8'h03);
    w(12'h01C, 8'h02);
    w(12'h01C, 8'h00);
    rc(12'h408, 32'h0000_00FF, 2'h0, "aborted");
    w(12'h01C, 8'hF8);
    rc(12'h01C, 32'h0000_0008, 2'h0, "upper");
    chk("aux", 32'(aux), 32'h0000_0001);
    w(12'h01C, 8'h00);
  endtask

  // Verdict, reached by the main sequence or by the watchdog.
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence after a twelve cycle reset.
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_program();
    t_erase();
    t_map();
    conclude();
  end

  // The run needs under two hundred cycles; four thousand means a hang.
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule // eepc_byte_program_erase_ctrl_tb

`default_nettype wire
